// ===== common/sysctl_pkg.sv
// Constants and types shared by the supply monitor and system control block.
//
// Operation
// RULE1 - Power-on monitoring of core and I/O rails is never gated off.
// RULE2 - I/O brown-out after power-up; core brown-out only with regulator on.
// RULE3 - Reset pin driven low on any under-voltage, released after a delay.
// RULE4 - With regulator on, core over-voltage also drives the reset pin low.
// RULE5 - One config bit disables brown-out monitors on both rails together.
// RULE6 - Strap low enables regulator and core brown-out; high disables both.
// RULE7 - Both oscillators on at power-up, oscillator one is default source.
// RULE8 - Each oscillator powers down by software; own trim sets frequency.
// RULE9 - Block registers accept writes only while protected write is enabled.
// RULE10 - CPU input clock is passed out as system clock at same frequency.
// RULE11 - Each register is one 16-bit word at its listed address.
// RULE12 - PLL control and status reset only by pin or watchdog reset.
// RULE13 - Supply or watchdog reset asserts device reset and drives reset pin.

package sysctl_pkg;

   // --------------------------------------------------------------
   // Register indices, byte address is four times the index
   // --------------------------------------------------------------
   localparam int          NUM_REGS         = 18;
   localparam int          DATA_W           = 16;
   localparam logic [23:0] BROWNOUT_CONFIG  = 24'h000985;
   localparam logic [23:0] CLOCK_OUTPUT_CTL = 24'h007010;
   localparam logic [23:0] PLL_STATUS       = 24'h007011;
   localparam logic [23:0] CLOCK_SOURCE_CTL = 24'h007012;
   localparam logic [23:0] PLL_LOCK_PERIOD  = 24'h007013;
   localparam logic [23:0] OSC_ONE_TRIM     = 24'h007014;
   localparam logic [23:0] OSC_TWO_TRIM     = 24'h007016;
   localparam logic [23:0] SLOW_PRESCALER   = 24'h00701B;
   localparam logic [23:0] PERIPH_GATE_0    = 24'h00701C;
   localparam logic [23:0] PERIPH_GATE_1    = 24'h00701D;
   localparam logic [23:0] LOW_POWER_CTL    = 24'h00701E;
   localparam logic [23:0] PERIPH_GATE_3    = 24'h007020;
   localparam logic [23:0] PLL_MULT_CTL     = 24'h007021;
   localparam logic [23:0] SYS_CTRL_STATUS  = 24'h007022;
   localparam logic [23:0] WATCHDOG_COUNT   = 24'h007023;
   localparam logic [23:0] PERIPH_GATE_4    = 24'h007024;
   localparam logic [23:0] WATCHDOG_KEY     = 24'h007025;
   localparam logic [23:0] WATCHDOG_CTL     = 24'h007029;

   localparam logic [23:0] REG_INDEX [NUM_REGS] = '{
      BROWNOUT_CONFIG, CLOCK_OUTPUT_CTL, PLL_STATUS, CLOCK_SOURCE_CTL,
      PLL_LOCK_PERIOD, OSC_ONE_TRIM, OSC_TWO_TRIM, SLOW_PRESCALER,
      PERIPH_GATE_0, PERIPH_GATE_1, LOW_POWER_CTL, PERIPH_GATE_3,
      PLL_MULT_CTL, SYS_CTRL_STATUS, WATCHDOG_COUNT, PERIPH_GATE_4,
      WATCHDOG_KEY, WATCHDOG_CTL};

   // --------------------------------------------------------------
   // Storage slots with behaviour of their own
   // --------------------------------------------------------------
   localparam int SLOT_BOR    = 0;
   localparam int SLOT_PLL_STATUS = 2;
   localparam int SLOT_CLOCK_SOURCE_CONTROL = 3;
   localparam int SLOT_TRIM1  = 5;
   localparam int SLOT_TRIM2  = 6;
   localparam int SLOT_PLL_MULTIPLIER_CONTROL  = 12;
   localparam int SLOT_STATUS = 13;

   // --------------------------------------------------------------
   // Field positions and values after reset
   // --------------------------------------------------------------
   localparam int          BOR_DISABLE_BIT = 0;
   localparam int          OSC1_OFF_BIT    = 0;
   localparam int          OSC2_OFF_BIT    = 1;
   localparam int          OSC_SEL_BIT     = 2;
   localparam int          ST_SUPPLY_RST   = 0;
   localparam int          ST_REG_EN       = 1;
   localparam int          ST_POWERED_UP   = 2;
   localparam int          ST_BOR_ACTIVE   = 3;
   localparam logic [15:0] CLOCK_SOURCE_CONTROL_RESET    = 16'h0000;
   localparam logic [15:0] REG_RESET       = 16'h0000;

   // --------------------------------------------------------------
   // Timing
   // --------------------------------------------------------------
   localparam int RELEASE_US     = 1000;
   localparam int CLK_MHZ        = 10;
   localparam int RELEASE_CYCLES = RELEASE_US * CLK_MHZ;
   localparam int CNT_W          = 20;

   // --------------------------------------------------------------
   // Synchroniser bit positions
   // --------------------------------------------------------------
   localparam int SY_CORE_POR = 0;
   localparam int SY_IO_POR   = 1;
   localparam int SY_CORE_BOR = 2;
   localparam int SY_IO_BOR   = 3;
   localparam int SY_CORE_OV  = 4;
   localparam int SY_STRAP    = 5;
   localparam int SY_PIN      = 6;
   localparam int SY_CPU_CLK  = 7;
   localparam int SYNC_W      = 8;

   typedef struct packed {
      logic core_por_low;
      logic io_por_low;
      logic core_bor_low;
      logic io_bor_low;
      logic core_ov_high;
   } supply_flags_type;

   typedef struct packed {
      logic osc_one_enable;
      logic osc_two_enable;
      logic osc_two_select;
      logic [15:0] osc_one_trim;
      logic [15:0] osc_two_trim;
   } osc_ctrl_type;

   typedef struct packed {
      logic [SYNC_W-1:0] sync1;
      logic [SYNC_W-1:0] sync2;
      logic powered_up;
      logic [CNT_W-1:0] release_cnt;
      logic supply_reset;
      logic device_reset_n;
      logic pin_oe;
      logic reg_enable;
      logic sysclk_out;
      osc_ctrl_type osc;
      logic [NUM_REGS-1:0][15:0] regs;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } state_type;

endpackage

// ===== rtl/supply_monitor_reset_and_osc_select.sv
// Supply monitor reset generator with oscillator defaults and control registers.
`timescale 1ns/10ps
`default_nettype none

module supply_monitor_reset_and_osc_select #(
   parameter int RELEASE_CYCLES = sysctl_pkg::RELEASE_CYCLES
) (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [31:0]                  paddr,
   input  wire logic [31:0]                  pwdata,
   output var  logic [31:0]                  prdata,
   output var  logic                         pready,
   output var  logic                         pslverr,
   input  wire sysctl_pkg::supply_flags_type supply_flags,
   input  wire logic                         regulator_disable_strap,
   input  wire logic                         external_reset_pin_in,
   output var  logic                         external_reset_pin_out,
   output var  logic                         external_reset_pin_oe,
   input  wire logic                         protected_write_enable,
   input  wire logic                         watchdog_reset_signal,
   input  wire logic                         debug_reset_req,
   input  wire logic                         missing_clock_reset_req,
   input  wire logic                         cpu_input_clock,
   output var  logic                         system_clock_output,
   output var  logic                         core_regulator_enable,
   output var  logic                         supply_monitor_reset_signal,
   output var  logic                         device_reset_n,
   output var  sysctl_pkg::osc_ctrl_type     osc_ctrl
);

   // --------------------------------------------------------------
   // State
   // --------------------------------------------------------------
   sysctl_pkg::state_type           st_r;
   sysctl_pkg::state_type           st_nxt;
   logic [sysctl_pkg::SYNC_W-1:0]   raw_in;
   logic [sysctl_pkg::CNT_W-1:0]    release_load;

   assign release_load = sysctl_pkg::CNT_W'(RELEASE_CYCLES);

   assign raw_in = {cpu_input_clock,
                    external_reset_pin_in,
                    regulator_disable_strap,
                    supply_flags.core_ov_high,
                    supply_flags.io_bor_low,
                    supply_flags.core_bor_low,
                    supply_flags.io_por_low,
                    supply_flags.core_por_low};

   // --------------------------------------------------------------
   // Next state
   // --------------------------------------------------------------
   always_comb begin
      logic        reg_en;
      logic        bor_en;
      logic        por_low;
      logic        bor_low;
      logic        ov_high;
      logic        fault;
      logic        pin_low;
      logic        gen_rst;
      logic        pll_rst;
      logic        hit;
      logic [4:0]  slot;
      logic        access;
      logic [15:0] rd_word;
      reg_en  = 1'b0;
      bor_en  = 1'b0;
      por_low = 1'b0;
      bor_low = 1'b0;
      ov_high = 1'b0;
      fault   = 1'b0;
      pin_low = 1'b0;
      gen_rst = 1'b0;
      pll_rst = 1'b0;
      hit     = 1'b0;
      slot    = 5'h00;
      access  = 1'b0;
      rd_word = 16'h0000;
      st_nxt  = st_r;

      // Second stage alone feeds the logic below.
      st_nxt.sync1 = raw_in;
      st_nxt.sync2 = st_r.sync1;

      // RULE6 strap sets regulator
      reg_en = ~st_r.sync2[sysctl_pkg::SY_STRAP];
      st_nxt.reg_enable = reg_en;

      // RULE1 power-on always watched
      por_low = st_r.sync2[sysctl_pkg::SY_CORE_POR]
              | st_r.sync2[sysctl_pkg::SY_IO_POR];
      if (!por_low) begin
         st_nxt.powered_up = 1'b1;
      end

      // RULE5 one disable bit
      bor_en = st_r.powered_up
             & ~st_r.regs[sysctl_pkg::SLOT_BOR][sysctl_pkg::BOR_DISABLE_BIT];

      // RULE2 brown-out rail selection
      bor_low = bor_en & (st_r.sync2[sysctl_pkg::SY_IO_BOR]
              | (reg_en & st_r.sync2[sysctl_pkg::SY_CORE_BOR]));

      // RULE4 core over-voltage
      ov_high = reg_en & st_r.sync2[sysctl_pkg::SY_CORE_OV];

      // RULE3 hold then delayed release
      fault = por_low | bor_low | ov_high;
      if (fault) begin
         st_nxt.supply_reset = 1'b1;
         st_nxt.release_cnt  = release_load;
      end else if (st_r.release_cnt != '0) begin
         st_nxt.release_cnt = st_r.release_cnt - 1'b1;
      end else begin
         st_nxt.supply_reset = 1'b0;
      end

      // RULE13 both sources reset device
      st_nxt.device_reset_n = ~(st_r.supply_reset | watchdog_reset_signal);
      st_nxt.pin_oe         = st_r.supply_reset | watchdog_reset_signal;

      // RULE10 clock passed through
      st_nxt.sysclk_out = st_r.sync2[sysctl_pkg::SY_CPU_CLK];

      // Pin reset is sensed on the wire, so it also covers our own drive.
      pin_low = ~st_r.sync2[sysctl_pkg::SY_PIN];
      pll_rst = pin_low | watchdog_reset_signal;
      gen_rst = pll_rst | debug_reset_req | missing_clock_reset_req;

      // RULE11 one word per index
      for (int i = 0; i < sysctl_pkg::NUM_REGS; i++) begin
         if (paddr == {6'h00, sysctl_pkg::REG_INDEX[i], 2'b00}) begin
            hit  = 1'b1;
            slot = 5'(i);
         end
      end

      // One wait state: pready rises on the second access cycle.
      access = psel & penable;
      st_nxt.pready  = access & ~st_r.pready;
      st_nxt.pslverr = access & ~st_r.pready & ~hit;
      if (access & ~st_r.pready) begin
         rd_word = hit ? st_r.regs[slot] : 16'h0000;
         st_nxt.prdata = {16'h0000, rd_word};
      end

      // RULE9 protected writes
      if (access & st_r.pready & pwrite & hit & protected_write_enable
          & (slot != 5'(sysctl_pkg::SLOT_STATUS))) begin
         st_nxt.regs[slot] = pwdata[15:0];
      end

      // RULE12 PLL registers keep value
      if (gen_rst) begin
         for (int i = 0; i < sysctl_pkg::NUM_REGS; i++) begin
            if (i != sysctl_pkg::SLOT_PLL_MULTIPLIER_CONTROL && i != sysctl_pkg::SLOT_PLL_STATUS)
            begin
               st_nxt.regs[i] = sysctl_pkg::REG_RESET;
            end
         end
         st_nxt.regs[sysctl_pkg::SLOT_CLOCK_SOURCE_CONTROL] = sysctl_pkg::CLOCK_SOURCE_CONTROL_RESET;
      end
      if (pll_rst) begin
         st_nxt.regs[sysctl_pkg::SLOT_PLL_MULTIPLIER_CONTROL]  = sysctl_pkg::REG_RESET;
         st_nxt.regs[sysctl_pkg::SLOT_PLL_STATUS] = sysctl_pkg::REG_RESET;
      end

      // Status word mirrors live state and ignores writes.
      st_nxt.regs[sysctl_pkg::SLOT_STATUS] = 16'h0000;
      st_nxt.regs[sysctl_pkg::SLOT_STATUS][sysctl_pkg::ST_SUPPLY_RST] =
         st_r.supply_reset;
      st_nxt.regs[sysctl_pkg::SLOT_STATUS][sysctl_pkg::ST_REG_EN] = reg_en;
      st_nxt.regs[sysctl_pkg::SLOT_STATUS][sysctl_pkg::ST_POWERED_UP] =
         st_r.powered_up;
      st_nxt.regs[sysctl_pkg::SLOT_STATUS][sysctl_pkg::ST_BOR_ACTIVE] =
         bor_en;

      // RULE8 software power-down and trim
      st_nxt.osc.osc_one_enable = ~st_r.regs[sysctl_pkg::SLOT_CLOCK_SOURCE_CONTROL]
                                           [sysctl_pkg::OSC1_OFF_BIT];
      st_nxt.osc.osc_two_enable = ~st_r.regs[sysctl_pkg::SLOT_CLOCK_SOURCE_CONTROL]
                                           [sysctl_pkg::OSC2_OFF_BIT];
      st_nxt.osc.osc_two_select = st_r.regs[sysctl_pkg::SLOT_CLOCK_SOURCE_CONTROL]
                                          [sysctl_pkg::OSC_SEL_BIT];
      st_nxt.osc.osc_one_trim   = st_r.regs[sysctl_pkg::SLOT_TRIM1];
      st_nxt.osc.osc_two_trim   = st_r.regs[sysctl_pkg::SLOT_TRIM2];
   end

   // --------------------------------------------------------------
   // Registers
   // --------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
         // The reset pin is assumed high and the strap and rails low until sampled, so reset holds.
         st_r.supply_reset <= 1'b1;
         st_r.pin_oe <= 1'b1;
         st_r.release_cnt <= sysctl_pkg::CNT_W'(RELEASE_CYCLES);
         st_r.sync1 <= 8'h40;
         st_r.sync2 <= 8'h40;
         st_r.regs[sysctl_pkg::SLOT_CLOCK_SOURCE_CONTROL] <= sysctl_pkg::CLOCK_SOURCE_CONTROL_RESET;
         // RULE7 both oscillators on, first selected
         st_r.osc.osc_one_enable <= 1'b1;
         st_r.osc.osc_two_enable <= 1'b1;
         st_r.osc.osc_two_select <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // --------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------
   assign prdata                      = st_r.prdata;
   assign pready                      = st_r.pready;
   assign pslverr                     = st_r.pslverr;
   assign external_reset_pin_out      = 1'b0;
   assign external_reset_pin_oe       = st_r.pin_oe;
   assign system_clock_output         = st_r.sysclk_out;
   assign core_regulator_enable       = st_r.reg_enable;
   assign supply_monitor_reset_signal = st_r.supply_reset;
   assign device_reset_n              = st_r.device_reset_n;
   assign osc_ctrl                    = st_r.osc;

endmodule

`default_nettype wire

// ===== testbench/board_model.sv
// Board side model: supply rails, regulator strap and pulled-up reset wire.
`timescale 1ns/10ps
`default_nettype none

module board_model (
   input  wire logic                         pin_oe,
   input  wire logic                         pin_drive,
   input  wire logic                         strap_req,
   input  wire sysctl_pkg::supply_flags_type fault_req,
   output var  logic                         pin_level,
   output var  logic                         strap,
   output var  sysctl_pkg::supply_flags_type rails
);
   // ----------------------------------------------------------
   // Wire levels
   // ----------------------------------------------------------
   // pulled-up reset wire
   assign pin_level = pin_oe ? pin_drive : 1'h1;
   assign strap = strap_req;
   assign rails = fault_req;
endmodule

`default_nettype wire

// ===== testbench/sysctl_monitor.sv
// Checker for reset, supply trip, clock copy and bus answer timing.
`timescale 1ns/10ps
`default_nettype none

module sysctl_monitor #(
   parameter int RELEASE_CYCLES = sysctl_pkg::RELEASE_CYCLES
) (
   input wire logic                         pclk,
   input wire logic                         presetn,
   input wire logic                         psel,
   input wire logic                         penable,
   input wire logic [31:0]                  prdata,
   input wire logic                         pready,
   input wire sysctl_pkg::supply_flags_type supply_flags,
   input wire logic                         regulator_disable_strap,
   input wire logic                         external_reset_pin_oe,
   input wire logic                         watchdog_reset_signal,
   input wire logic                         cpu_input_clock,
   input wire logic                         system_clock_output,
   input wire logic                         core_regulator_enable,
   input wire logic                         supply_monitor_reset_signal,
   input wire logic                         device_reset_n
);
   // ----------------------------------------------------------
   // Properties
   // ----------------------------------------------------------
   logic [2:0] age_r;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // The clock copy is judged only once its pipe has filled.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         age_r <= 3'h0;
      else if (age_r != 3'h7)
         age_r <= age_r + 3'h1;
   end
   a_supply_to_pin: assert property (
      supply_monitor_reset_signal |=> external_reset_pin_oe)
      else $error("pin not driven during supply reset");
   a_release_hold: assert property (
      $rose(supply_monitor_reset_signal) |=> supply_monitor_reset_signal[*8])
      else $error("supply reset released too early");
   a_release_pin: assert property (
      $fell(supply_monitor_reset_signal) && !watchdog_reset_signal
      |=> !external_reset_pin_oe)
      else $error("pin still driven after release");
   a_por_trips: assert property (
      supply_flags.core_por_low || supply_flags.io_por_low
      |-> ##3 supply_monitor_reset_signal)
      else $error("power-on fault did not trip");
   a_ov_trips: assert property (
      supply_flags.core_ov_high && core_regulator_enable
      |-> ##3 supply_monitor_reset_signal)
      else $error("over-voltage did not trip");
   a_strap_off: assert property (
      regulator_disable_strap[*4] |-> !core_regulator_enable)
      else $error("regulator on with strap high");
   a_wd_to_pin: assert property (
      watchdog_reset_signal |=> external_reset_pin_oe && !device_reset_n)
      else $error("watchdog reset not passed on");
   a_dev_reset: assert property (
      supply_monitor_reset_signal |=> !device_reset_n)
      else $error("device reset missing");
   a_sysclk_copy: assert property (
      age_r == 3'h7 |-> system_clock_output == $past(cpu_input_clock, 3))
      else $error("system clock not a copy");
   a_bus_answer: assert property (
      psel && penable && !pready |=> pready)
      else $error("bus answer late");
   a_upper_zero: assert property (
      pready |-> prdata[31:16] == 16'h0000)
      else $error("upper read bits set");
   cover property ($rose(supply_monitor_reset_signal));
   cover property (watchdog_reset_signal);
   cover property (pready && psel);
endmodule

bind supply_monitor_reset_and_osc_select sysctl_monitor #(
   .RELEASE_CYCLES(RELEASE_CYCLES)) mon_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .prdata(prdata), .pready(pready), .supply_flags(supply_flags),
   .regulator_disable_strap(regulator_disable_strap),
   .external_reset_pin_oe(external_reset_pin_oe),
   .watchdog_reset_signal(watchdog_reset_signal),
   .cpu_input_clock(cpu_input_clock),
   .system_clock_output(system_clock_output),
   .core_regulator_enable(core_regulator_enable),
   .supply_monitor_reset_signal(supply_monitor_reset_signal),
   .device_reset_n(device_reset_n));

`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the supply monitor and system control block.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   // ----------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------
   logic        pclk, presetn, psel, penable, pwrite, pwe, wdr, dbg, mck;
   logic        cpu_clk, strap_req, pready, pslverr, pin_oe, pin_out, pin;
   logic        strap, sysclk, reg_en, sup_rst, dev_rst_n, err;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [15:0] v;
   logic [15:0] exp_r [sysctl_pkg::NUM_REGS];
   int          failures, n_checks, seed;
   sysctl_pkg::supply_flags_type fault, flags;
   sysctl_pkg::osc_ctrl_type     osc;
   logic [2:0]                   osc_bits;
   supply_monitor_reset_and_osc_select #(.RELEASE_CYCLES(8))
      supply_monitor_reset_and_osc_select_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .supply_flags(flags),
      .regulator_disable_strap(strap), .external_reset_pin_in(pin),
      .external_reset_pin_out(pin_out), .external_reset_pin_oe(pin_oe),
      .protected_write_enable(pwe), .watchdog_reset_signal(wdr),
      .debug_reset_req(dbg), .missing_clock_reset_req(mck),
      .cpu_input_clock(cpu_clk), .system_clock_output(sysclk),
      .core_regulator_enable(reg_en), .supply_monitor_reset_signal(sup_rst),
      .device_reset_n(dev_rst_n), .osc_ctrl(osc));
   board_model board_model_i (.pin_oe(pin_oe), .pin_drive(pin_out),
      .strap_req(strap_req), .fault_req(fault), .pin_level(pin),
      .strap(strap), .rails(flags));
   assign osc_bits = {osc.osc_one_enable, osc.osc_two_enable,
                      osc.osc_two_select};
   always #50 pclk = ~pclk;
   always @(posedge pclk) cpu_clk <= ~cpu_clk;
   // ----------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------
   function automatic logic [2:0] osc_exp(input logic [15:0] c);
      return {~c[0], ~c[1], c[2]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      if (failures == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [23:0] idx,
                      input logic [15:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {6'h00, idx, 2'h0};
      pwdata <= {~d, d};
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      chk(pready, 1'h1);
   endtask
   // Waits for the pin to come free; registers stay held until then.
   task automatic settle;
      int n;
      n = 0;
      while (dev_rst_n !== 1'h1 && n < 300) begin
         @(posedge pclk);
         n++;
      end
      chk(dev_rst_n, 1'h1);
      tick(6);
   endtask
   task automatic trip(input int b, input logic want);
      @(posedge pclk);
      fault <= sysctl_pkg::supply_flags_type'(5'h01 << b);
      tick(5);
      chk(sup_rst, want);
      fault <= 5'h00;
      settle;
   endtask
   // ----------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------
   initial begin
      {psel, penable, pwrite, pwe, wdr, dbg, mck, cpu_clk} = 8'h00;
      {pclk, presetn, strap_req} = 3'h0;
      {paddr, pwdata} = 64'h0;
      fault = 5'h00;
      failures = 0;
      n_checks = 0;
      seed = 32'h75B7;
      tick(12);
      chk(pin_oe, 1'h1);
      presetn <= 1'h1;
      settle;
      chk(osc_bits, 3'h6);
      for (int i = 0; i < sysctl_pkg::NUM_REGS; i++) begin
         if (i == sysctl_pkg::SLOT_STATUS)
            continue;
         v = 16'($random(seed));
         exp_r[i] = v;
         pwe <= 1'h0;
         apb(1'h1, sysctl_pkg::REG_INDEX[i], v);
         apb(1'h0, sysctl_pkg::REG_INDEX[i], 16'h0000);
         chk(rd, 32'h0);
         pwe <= 1'h1;
         apb(1'h1, sysctl_pkg::REG_INDEX[i], v);
         apb(1'h0, sysctl_pkg::REG_INDEX[i], 16'h0000);
         chk(rd, {16'h0000, v});
      end
      v = exp_r[sysctl_pkg::SLOT_CLOCK_SOURCE_CONTROL];
      chk(osc_bits, osc_exp(v));
      chk(osc.osc_one_trim, exp_r[sysctl_pkg::SLOT_TRIM1]);
      chk(osc.osc_two_trim, exp_r[sysctl_pkg::SLOT_TRIM2]);
      apb(1'h0, sysctl_pkg::SYS_CTRL_STATUS, 16'h0000);
      chk(rd[1], 1'h1);
      apb(1'h0, 24'h007015, 16'h0000);
      chk(err, 1'h1);
      chk(rd, 32'h0);
      for (int k = 0; k < 2; k++) begin
         apb(1'h1, sysctl_pkg::CLOCK_SOURCE_CTL, 16'h0007);
         dbg <= (k == 0);
         mck <= (k == 1);
         @(posedge pclk);
         {dbg, mck} <= 2'h0;
         apb(1'h0, sysctl_pkg::CLOCK_SOURCE_CTL, 16'h0000);
         chk(rd, 32'h0);
         apb(1'h0, sysctl_pkg::PLL_MULT_CTL, 16'h0000);
         chk(rd, {16'h0000, exp_r[sysctl_pkg::SLOT_PLL_MULTIPLIER_CONTROL]});
      end
      wdr <= 1'h1;
      @(posedge pclk);
      wdr <= 1'h0;
      tick(1);
      chk(dev_rst_n, 1'h0);
      settle;
      apb(1'h0, sysctl_pkg::PLL_MULT_CTL, 16'h0000);
      chk(rd, 32'h0);
      apb(1'h1, sysctl_pkg::BROWNOUT_CONFIG, 16'h0001);
      trip(1, 1'h0);
      trip(2, 1'h0);
      trip(3, 1'h1);
      trip(4, 1'h1);
      trip(1, 1'h1);
      trip(2, 1'h1);
      trip(0, 1'h1);
      strap_req <= 1'h1;
      tick(6);
      chk(reg_en, 1'h0);
      trip(2, 1'h0);
      trip(0, 1'h0);
      trip(1, 1'h1);
      report_and_stop;
   end
   initial begin
      #2000000;
      failures++;
      report_and_stop;
   end
endmodule

`default_nettype wire
